/* rtl/fault_spi_pkg.sv */
// Purpose: Shared constants for the fault latch and SPI status block
// Assumes: Core clock of 20 MHz, byte-wide registers, MSB-first frames
// Notes: Times are in ns; cycle counts are derived from the clock period
package fault_spi_pkg;
  // Core clock period
  localparam int CLK_NS = 50;
  // Setup time after the enable pin rises, rounded up to cycles
  localparam int SETUP_NS = 10000;
  localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  // Open-load filter times, least times, rounded up to cycles
  localparam int OL_FILT_NS = 50000;
  localparam int OL_FILT_CYC = (OL_FILT_NS + CLK_NS - 1) / CLK_NS;
  localparam int LED_FILT_SHORT_NS = 10000;
  localparam int LED_FILT_SHORT_CYC = (LED_FILT_SHORT_NS + CLK_NS - 1) / CLK_NS;
  localparam int LED_FILT_LONG_NS = 20000;
  localparam int LED_FILT_LONG_CYC = (LED_FILT_LONG_NS + CLK_NS - 1) / CLK_NS;
  // Frame layout
  localparam int FRAME_BITS = 16;
  localparam int OP_BIT = 15;
  localparam int ADDR_MSB = 14;
  localparam int ADDR_LSB = 10;
  // Register addresses (5-bit field of the address byte)
  localparam logic [4:0] ADDR_GLOBAL = 5'h00;
  localparam logic [4:0] ADDR_ACT_HS = 5'h01;
  localparam logic [4:0] ADDR_ACT_LS = 5'h02;
  localparam logic [4:0] ADDR_OL_HS = 5'h03;
  localparam logic [4:0] ADDR_OL_LS = 5'h04;
  localparam logic [4:0] ADDR_LED_CFG = 5'h05;
  // Global status byte field positions
  localparam int GS_PROTO = 7;
  localparam int GS_LOAD = 6;
  localparam int GS_ULOW = 5;
  localparam int GS_UHIGH = 4;
  localparam int GS_RSTABS = 3;
  localparam int GS_TSD = 2;
  localparam int GS_TPW = 1;
  // LED open-load configuration fields
  localparam int LED_THR_BIT = 0;
  localparam int LED_FILT_BIT = 1;
  // Reset values
  localparam logic [7:0] CFG_RST = 8'h00;
endpackage

/* rtl/word_fifo.sv */
// Purpose: Small synchronous FIFO carrying received frames
// Assumes: Single clock, synchronous active-low reset, clock enable
// Notes: Full and empty come from an occupancy count
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0] cnt_reg;
  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;

  // Honest flags from the count
  assign in_ready_o = (cnt_reg != DEPTH[AW:0]);
  assign out_valid_o = (cnt_reg != '0);
  assign out_data_o = mem_reg[rd_reg];

  // Pointers wrap naturally; depth is a power of two
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else if (ce_i) begin
      if (push) begin
        mem_reg[wr_reg] <= in_data_i;
        wr_reg <= wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= rd_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule
`default_nettype wire

/* rtl/fault_latch_spi_status.sv */
// Purpose: Fault latching, output gating and 16-bit SPI slave with in-frame response
// Assumes: SPI pins and fault levels are asynchronous and are synchronised here
// Notes: SCLK edges are found by oversampling; SCLK must stay well below MCLK/4
//
// Operation
// RULE1 - Thermal warning latches pre-warning flag; outputs stay active.
// RULE2 - Thermal shutdown latches its flag and holds all outputs off until cleared.
// RULE3 - Cleared pre-warning flag reads one again while warning persists.
// RULE4 - Supply low turns outputs off, keeps registers, latches supply-low flag.
// RULE5 - Outputs return by themselves when supply recovers; master clears flag.
// RULE6 - Supply high turns outputs off, latches flag, outputs return automatically.
// RULE7 - Logic-supply reset stops SPI, initialises state, outputs high impedance.
// RULE8 - After logic reset the reset-absent flag reads zero.
// RULE9 - Low current on active switch for filter time latches open-load and load error.
// RULE10 - LED high sides use selectable lower threshold and filter time.
// RULE11 - Free-wheeling stages in PWM never set open-load flags.
// RULE12 - Master sends 16-bit frames under low chip select, clock idle low.
// RULE13 - Sample input on falling clock, shift output on rising clock.
// RULE14 - Addressed register content returns within the same frame.
// RULE15 - Act on word after chip select rises; then release serial output.
// RULE16 - Writes, clears and reads act on whole bytes.
// RULE17 - Device never clears status or configuration bits by itself.
// RULE18 - Frames before the setup time after enable rises are ignored.
// RULE19 - Before first rising clock, output shows global error OR serial input.
// RULE20 - Global error flag set on any fault or after power-on reset.
// RULE21 - Master holds serial input low until first rising clock.
// RULE22 - Zero-clock frame lets master poll the global error flag.
// RULE23 - Global error is OR of status flags and inverted reset-absent flag.
// RULE24 - Reset-absent flag resets to zero so global error starts at one.
// RULE25 - A flag cleared under a standing fault is set again at once.
`timescale 1ns/1ps
`default_nettype none
module fault_latch_spi_status #(
  parameter int NHB = 8,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic MCLK_I,
  input wire logic RESET_N_I,
  input wire logic CE_I,
  input wire logic EN_I,
  input wire logic SCLK_I,
  input wire logic CSN_I,
  input wire logic SDI_I,
  output logic SDO_O,
  output logic SDO_OE_N_O,
  input wire logic TEMP_WARN_I,
  input wire logic TEMP_SHUT_I,
  input wire logic SUPPLY_LOW_I,
  input wire logic SUPPLY_HIGH_I,
  input wire logic [NHB-1:0] HS_LOW_CUR_I,
  input wire logic [NHB-1:0] LS_LOW_CUR_I,
  input wire logic [NHB-1:0] HS_FREEWHEEL_I,
  input wire logic [NHB-1:0] LS_FREEWHEEL_I,
  output logic [NHB-1:0] HS_ON_O,
  output logic [NHB-1:0] LS_ON_O,
  output logic LED_LOW_THRESH_O
);
  localparam int NS = 8 + 4 * NHB;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers: first stage feeds only the second
  logic [NS-1:0] meta_reg;
  logic [NS-1:0] sync_reg;
  always_ff @(posedge MCLK_I) begin
    if (!RESET_N_I) begin
      meta_reg <= {{(NS-2){1'b0}}, 2'h2}; // Chip select idles high, so no false edge
      sync_reg <= {{(NS-2){1'b0}}, 2'h2};
    end else if (CE_I) begin
      meta_reg <= {LS_FREEWHEEL_I, HS_FREEWHEEL_I, LS_LOW_CUR_I, HS_LOW_CUR_I,
                   SUPPLY_HIGH_I, SUPPLY_LOW_I, TEMP_SHUT_I, TEMP_WARN_I,
                   EN_I, SDI_I, CSN_I, SCLK_I};
      sync_reg <= meta_reg;
    end
  end
  wire sclk_s = sync_reg[0];
  wire csn_s = sync_reg[1];
  wire sdi_s = sync_reg[2];
  wire en_s = sync_reg[3];
  wire warn_s = sync_reg[4];
  wire shut_s = sync_reg[5];
  wire ulow_s = sync_reg[6];
  wire uhigh_s = sync_reg[7];
  wire [2*NHB-1:0] lowcur_s = sync_reg[8 +: 2*NHB];
  wire [2*NHB-1:0] fw_s = sync_reg[8+2*NHB +: 2*NHB];

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection on the synchronised link signals
  logic sclk_d_reg;
  logic csn_d_reg;
  always_ff @(posedge MCLK_I) begin
    if (!RESET_N_I) begin
      sclk_d_reg <= 1'b0;
      csn_d_reg <= 1'b1;
    end else if (CE_I) begin
      sclk_d_reg <= sclk_s;
      csn_d_reg <= csn_s;
    end
  end
  wire sclk_rise = sclk_s && !sclk_d_reg;
  wire sclk_fall = !sclk_s && sclk_d_reg;
  wire csn_fall = !csn_s && csn_d_reg;
  wire csn_rise = csn_s && !csn_d_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Enable setup timer; frames are recognised only once it has expired
  logic [15:0] setup_reg;
  wire setup_done = (setup_reg == 16'(fault_spi_pkg::SETUP_CYC));
  always_ff @(posedge MCLK_I) begin
    if (!RESET_N_I) begin
      setup_reg <= '0;
    end else if (CE_I) begin
      if (!en_s) begin
        setup_reg <= '0; // RULE18
      end else if (!setup_done) begin
        setup_reg <= setup_reg + 16'h0001; // RULE18
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration and latched flags
  logic [NHB-1:0] hs_en_reg;
  logic [NHB-1:0] ls_en_reg;
  logic [7:0] led_cfg_reg;
  logic [NHB-1:0] ol_hs_reg;
  logic [NHB-1:0] ol_ls_reg;
  logic tpw_reg;
  logic tsd_reg;
  logic ulow_reg;
  logic uhigh_reg;
  logic load_reg;
  logic proto_reg;
  logic rstabs_reg;

  // Global status byte and the error summary
  wire [7:0] gstat = {proto_reg, load_reg, ulow_reg, uhigh_reg,
                      rstabs_reg, tsd_reg, tpw_reg, 1'b0};
  wire global_error_flag = proto_reg | load_reg | ulow_reg | uhigh_reg |
             !rstabs_reg | tsd_reg | tpw_reg; // RULE20 RULE23

  ////////////////////////////////////////////////////////////////////////////
  // Serial receive and in-frame transmit
  logic active_reg;
  logic clocked_reg;
  logic [4:0] rcnt_reg;
  logic [4:0] fcnt_reg;
  logic [15:0] rx_reg;
  logic [15:0] tx_reg;
  logic sdo_reg;
  logic sdo_oe_n_reg;
  wire [4:0] rx_addr = rx_reg[6:2];
  wire resp_load = (rcnt_reg == 5'h08);

  // Response byte for the address just received; status reads see latched state
  wire [7:0] resp_byte =
    (rx_addr == fault_spi_pkg::ADDR_GLOBAL) ? gstat :
    (rx_addr == fault_spi_pkg::ADDR_ACT_HS) ? 8'(hs_en_reg) :
    (rx_addr == fault_spi_pkg::ADDR_ACT_LS) ? 8'(ls_en_reg) :
    (rx_addr == fault_spi_pkg::ADDR_OL_HS) ? 8'(ol_hs_reg) :
    (rx_addr == fault_spi_pkg::ADDR_OL_LS) ? 8'(ol_ls_reg) :
    (rx_addr == fault_spi_pkg::ADDR_LED_CFG) ? led_cfg_reg : 8'h00;

  // Frame bookkeeping; a frame starting before setup is never tracked
  always_ff @(posedge MCLK_I) begin
    if (!RESET_N_I) begin
      active_reg <= 1'b0;
      clocked_reg <= 1'b0;
      rcnt_reg <= '0;
      fcnt_reg <= '0;
      rx_reg <= '0;
      tx_reg <= '0;
    end else if (CE_I) begin
      if (csn_fall) begin
        active_reg <= setup_done && en_s; // RULE18
        clocked_reg <= 1'b0;
        rcnt_reg <= '0;
        fcnt_reg <= '0;
        tx_reg <= {gstat, 8'h00};
      end else if (csn_rise) begin
        active_reg <= 1'b0;
      end else if (active_reg) begin
        if (sclk_fall) begin
          rx_reg <= {rx_reg[14:0], sdi_s}; // RULE13
          if (fcnt_reg != 5'h1f) begin
            fcnt_reg <= fcnt_reg + 5'h01;
          end
        end
        if (sclk_rise) begin
          clocked_reg <= 1'b1;
          tx_reg <= resp_load ? {resp_byte[6:0], 9'h000} : {tx_reg[14:0], 1'b0}; // RULE14
          if (rcnt_reg != 5'h1f) begin
            rcnt_reg <= rcnt_reg + 5'h01;
          end
        end
      end
    end
  end

  // Serial output: error summary before the first clock, then the shift register
  always_ff @(posedge MCLK_I) begin
    if (!RESET_N_I) begin
      sdo_reg <= 1'b0;
      sdo_oe_n_reg <= 1'b1; // RULE7
    end else if (CE_I) begin
      sdo_oe_n_reg <= !(active_reg && !csn_s); // RULE15
      if (active_reg && !clocked_reg && !sclk_rise) begin
        sdo_reg <= global_error_flag | sdi_s; // RULE19 RULE22
      end else if (active_reg && sclk_rise) begin
        sdo_reg <= resp_load ? resp_byte[7] : tx_reg[15]; // RULE13 RULE14
      end
    end
  end
  assign SDO_O = sdo_reg;
  assign SDO_OE_N_O = sdo_oe_n_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Completed frames queue up and are executed when no frame is in progress
  wire frame_ok = (fcnt_reg == 5'(fault_spi_pkg::FRAME_BITS));
  wire frame_bad = (fcnt_reg != 5'h00) && !frame_ok;
  wire push_req = active_reg && csn_rise && frame_ok; // RULE15
  wire push_ready;
  wire pop_valid;
  wire [15:0] cmd;
  wire pop_ready = !active_reg;

  word_fifo #(
    .WIDTH(fault_spi_pkg::FRAME_BITS),
    .DEPTH(FIFO_DEPTH)
  ) u_cmd_fifo (
    .clk_i(MCLK_I),
    .rst_n_i(RESET_N_I),
    .ce_i(CE_I),
    .in_valid_i(push_req),
    .in_ready_o(push_ready),
    .in_data_i(rx_reg),
    .out_valid_o(pop_valid),
    .out_ready_i(pop_ready),
    .out_data_o(cmd)
  );

  // Command decode: whole-byte writes and whole-byte clears only
  wire exec = pop_valid && pop_ready && cmd[fault_spi_pkg::OP_BIT];
  wire [4:0] cmd_addr = cmd[fault_spi_pkg::ADDR_MSB:fault_spi_pkg::ADDR_LSB];
  wire [7:0] cmd_data = cmd[7:0];
  wire clr_global = exec && (cmd_addr == fault_spi_pkg::ADDR_GLOBAL); // RULE16
  wire clr_ol_hs = exec && (cmd_addr == fault_spi_pkg::ADDR_OL_HS); // RULE16
  wire clr_ol_ls = exec && (cmd_addr == fault_spi_pkg::ADDR_OL_LS); // RULE16
  wire wr_hs = exec && (cmd_addr == fault_spi_pkg::ADDR_ACT_HS);
  wire wr_ls = exec && (cmd_addr == fault_spi_pkg::ADDR_ACT_LS);
  wire wr_led = exec && (cmd_addr == fault_spi_pkg::ADDR_LED_CFG);
  // A dropped or wrong-length frame is a protocol fault
  wire proto_set = (active_reg && csn_rise && frame_bad) || (push_req && !push_ready);

  ////////////////////////////////////////////////////////////////////////////
  // Open-load filters, one per switch; LED high sides use their own filter time
  wire [2*NHB-1:0] sw_on = {LS_ON_O, HS_ON_O};
  logic [2*NHB-1:0] ol_hit;
  wire [9:0] led_filt = led_cfg_reg[fault_spi_pkg::LED_FILT_BIT] ?
                        10'(fault_spi_pkg::LED_FILT_LONG_CYC) :
                        10'(fault_spi_pkg::LED_FILT_SHORT_CYC);
  genvar g;
  generate
    for (g = 0; g < 2 * NHB; g++) begin : g_ol
      logic [9:0] filt_reg;
      wire [9:0] limit = (g < 2) ? led_filt : 10'(fault_spi_pkg::OL_FILT_CYC); // RULE10
      wire watch = sw_on[g] && lowcur_s[g] && !fw_s[g]; // RULE9 RULE11
      assign ol_hit[g] = watch && (filt_reg == limit); // RULE9
      always_ff @(posedge MCLK_I) begin
        if (!RESET_N_I) begin
          filt_reg <= '0;
        end else if (CE_I) begin
          filt_reg <= !watch ? 10'h000 : (ol_hit[g] ? filt_reg : filt_reg + 10'h001);
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Flag latches: a standing cause beats a clear in the same cycle
  always_ff @(posedge MCLK_I) begin
    if (!RESET_N_I) begin
      tpw_reg <= 1'b0;
      tsd_reg <= 1'b0;
      ulow_reg <= 1'b0;
      uhigh_reg <= 1'b0;
      load_reg <= 1'b0;
      proto_reg <= 1'b0;
      rstabs_reg <= 1'b0; // RULE8 RULE24
      ol_hs_reg <= '0;
      ol_ls_reg <= '0;
    end else if (CE_I) begin
      tpw_reg <= warn_s | (tpw_reg & !clr_global); // RULE1 RULE3 RULE17
      tsd_reg <= shut_s | (tsd_reg & !clr_global); // RULE2 RULE17 RULE25
      ulow_reg <= ulow_s | (ulow_reg & !clr_global); // RULE4 RULE5
      uhigh_reg <= uhigh_s | (uhigh_reg & !clr_global); // RULE6
      load_reg <= (|ol_hit) | (load_reg & !clr_global); // RULE9
      proto_reg <= proto_set | (proto_reg & !clr_global);
      rstabs_reg <= rstabs_reg | clr_global; // RULE8
      ol_hs_reg <= ol_hit[NHB-1:0] | (ol_hs_reg & ~{NHB{clr_ol_hs}}); // RULE9 RULE25
      ol_ls_reg <= ol_hit[2*NHB-1:NHB] | (ol_ls_reg & ~{NHB{clr_ol_ls}}); // RULE9
    end
  end

  // Configuration registers, written a byte at a time
  always_ff @(posedge MCLK_I) begin
    if (!RESET_N_I) begin
      hs_en_reg <= '0;
      ls_en_reg <= '0;
      led_cfg_reg <= fault_spi_pkg::CFG_RST;
    end else if (CE_I) begin
      if (wr_hs) begin
        hs_en_reg <= cmd_data[NHB-1:0]; // RULE16
      end
      if (wr_ls) begin
        ls_en_reg <= cmd_data[NHB-1:0]; // RULE16
      end
      if (wr_led) begin
        led_cfg_reg <= cmd_data; // RULE10 RULE16
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output gating; enable bits stay set while stages are forced off
  wire gate_off = tsd_reg | ulow_s | uhigh_s; // RULE2 RULE4 RULE5 RULE6
  logic [NHB-1:0] hs_on_reg;
  logic [NHB-1:0] ls_on_reg;
  logic led_thr_reg;
  always_ff @(posedge MCLK_I) begin
    if (!RESET_N_I) begin
      hs_on_reg <= '0; // RULE7
      ls_on_reg <= '0; // RULE7
      led_thr_reg <= 1'b0;
    end else if (CE_I) begin
      hs_on_reg <= gate_off ? '0 : hs_en_reg; // RULE1 RULE9
      ls_on_reg <= gate_off ? '0 : ls_en_reg;
      led_thr_reg <= led_cfg_reg[fault_spi_pkg::LED_THR_BIT]; // RULE10
    end
  end
  assign HS_ON_O = hs_on_reg;
  assign LS_ON_O = ls_on_reg;
  assign LED_LOW_THRESH_O = led_thr_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  chk_shutdown_gates: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I) // RULE2
    CE_I && tsd_reg |=> (HS_ON_O == '0) && (LS_ON_O == '0))
    else $error("outputs on during thermal shutdown");
  chk_tpw_sticks: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I) // RULE3
    CE_I && warn_s |=> tpw_reg)
    else $error("pre-warning flag not held");
  chk_tpw_no_self: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I) // RULE17
    CE_I && tpw_reg && !clr_global |=> tpw_reg)
    else $error("pre-warning cleared without command");
  chk_supply_recover: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I) // RULE5
    CE_I && !tsd_reg && !ulow_s && !uhigh_s && hs_en_reg != '0 |=> HS_ON_O == $past(hs_en_reg))
    else $error("outputs not restored after supply recovery");
  chk_gef_summary: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I) // RULE23
    !rstabs_reg |-> global_error_flag)
    else $error("error summary misses reset flag");
  chk_release_sdo: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I) // RULE15
    CE_I && csn_rise |=> SDO_OE_N_O)
    else $error("serial output not released");
  chk_early_frame: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I) // RULE18
    CE_I && csn_fall && !setup_done |=> !active_reg)
    else $error("frame accepted before setup time");
  chk_poll_level: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I) // RULE19
    CE_I && active_reg && !clocked_reg && !sclk_rise |=> SDO_O == $past(global_error_flag | sdi_s))
    else $error("poll level wrong");
  chk_ol_latch: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I) // RULE9
    CE_I && (|ol_hit) |=> load_reg ##1 load_reg || $past(clr_global))
    else $error("load error not latched");
  chk_fw_blank: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I) // RULE11
    (fw_s & ol_hit) == '0)
    else $error("open load flagged on free-wheeling stage");
endmodule
`default_nettype wire

/* tb/spi_master_model.sv */
// Purpose: SPI master model driving the serial pins of the fault status block
// Assumes: Clock idle low, 8 MCLK per SCLK period (400 ns), MSB first
// Notes: SDO is sampled late in each bit, well after its 3-cycle lag
`timescale 1ns/1ps
`default_nettype none
module spi_master_model (
  input wire logic clk_i,
  input wire logic sdo_i,
  output logic sclk_o,
  output logic csn_o,
  output logic sdi_o
);
  // Idle: clock parked low, chip select high
  initial begin
    sclk_o = 1'b0;
    csn_o = 1'b1;
    sdi_o = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Frame of n clocks; n of zero is a bare error poll
  task automatic xfer(input int n, input logic [15:0] w, input logic s,
                      output logic [15:0] r, output logic g);
    r = 16'h0000;
    csn_o <= 1'b0;
    sdi_o <= s;
    tick(8);
    g = sdo_i;
    for (int i = 0; i < n; i++) begin
      sclk_o <= 1'b1;
      sdi_o <= w[15-i];
      tick(4);
      sclk_o <= 1'b0;
      tick(4);
      r[15-i] = sdo_i;
    end
    csn_o <= 1'b1;
    // Line released: drive the inverse so a stale bit cannot pass
    sdi_o <= ~sdi_o;
    tick(12);
  endtask
endmodule
`default_nettype wire

/* tb/tb_fault_latch_spi_status.sv */
// Purpose: Self-checking bench for fault latching and the SPI status slave
// Assumes: Expected values follow the fault rules and package addresses
// Notes: Only the clock enable is tied; every fault input is exercised
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin err_total++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, got, exp); end end
module tb_fault_latch_spi_status;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic en = 1'b0;
  logic warn = 1'b0;
  logic shut = 1'b0;
  logic ulow = 1'b0;
  logic uhigh = 1'b0;
  logic [7:0] hs_lc = 8'h00;
  logic [7:0] ls_lc = 8'h00;
  logic [7:0] ls_fw = 8'h00;
  logic [7:0] hs_fw = 8'h00;
  logic [7:0] hs_on, ls_on;
  logic sclk, csn, sdi, sdo, sdo_oe_n, led_thr, global_error_flag;
  logic sdo_last = 1'b0;
  logic [15:0] rsp;
  wire sdo_w;
  int err_total = 0;
  int num_checks = 0;
  int cyc = 0;

  initial begin
    forever #25 mclk = ~mclk;
  end

  // No pull on SDO: a released line shows the inverse of its last bit
  always @(posedge mclk) if (!sdo_oe_n) sdo_last <= sdo;
  assign sdo_w = sdo_oe_n ? ~sdo_last : sdo;

  fault_latch_spi_status DUT (.MCLK_I(mclk), .RESET_N_I(rst_n), .CE_I(ce), .EN_I(en),
    .SCLK_I(sclk), .CSN_I(csn), .SDI_I(sdi), .SDO_O(sdo), .SDO_OE_N_O(sdo_oe_n),
    .TEMP_WARN_I(warn), .TEMP_SHUT_I(shut), .SUPPLY_LOW_I(ulow), .SUPPLY_HIGH_I(uhigh),
    .HS_LOW_CUR_I(hs_lc), .LS_LOW_CUR_I(ls_lc), .HS_FREEWHEEL_I(hs_fw),
    .LS_FREEWHEEL_I(ls_fw), .HS_ON_O(hs_on), .LS_ON_O(ls_on), .LED_LOW_THRESH_O(led_thr));

  spi_master_model m (.clk_i(mclk), .sdo_i(sdo_w), .sclk_o(sclk), .csn_o(csn), .sdi_o(sdi));

  ////////////////////////////////////////////////////////////////////////////
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // Full frame: op bit, 5-bit address, data byte
  task automatic acc(input logic op, input logic [4:0] a, input logic [7:0] d);
    m.xfer(16, {op, a, 2'b00, d}, 1'b0, rsp, global_error_flag);
  endtask

  task automatic poll(input logic s, input logic e);
    m.xfer(0, 16'h0000, s, rsp, global_error_flag);
    `CHK(global_error_flag, e)
  endtask

  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Hang guard: the sequence needs well under 10000 cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      print_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    wt(2);
    rst_n <= 1'b1;
    wt(3);
    `CHK(sdo_oe_n, 1'b1)
    en <= 1'b1;
    acc(1'b1, fault_spi_pkg::ADDR_ACT_HS, 8'hFF);
    `CHK(hs_on, 8'h00)
    wt(fault_spi_pkg::SETUP_CYC);
    poll(1'b0, 1'b1);
    acc(1'b0, fault_spi_pkg::ADDR_GLOBAL, 8'h00);
    `CHK(rsp, 16'h0000)
    acc(1'b1, fault_spi_pkg::ADDR_GLOBAL, 8'h00);
    poll(1'b0, 1'b0);
    poll(1'b1, 1'b1);
    `CHK(sdo_oe_n, 1'b1)
    $display("test startup done");
    acc(1'b1, fault_spi_pkg::ADDR_ACT_HS, 8'h0F);
    `CHK(rsp, 16'h0800)
    acc(1'b1, fault_spi_pkg::ADDR_ACT_LS, 8'hF0);
    acc(1'b0, fault_spi_pkg::ADDR_ACT_HS, 8'h00);
    `CHK(rsp, 16'h080F)
    `CHK(ls_on, 8'hF0)
    $display("test enables done");
    // Warning is cleared while still present, then after it goes away
    warn <= 1'b1;
    wt(8);
    `CHK(hs_on, 8'h0F)
    acc(1'b1, fault_spi_pkg::ADDR_GLOBAL, 8'h00);
    acc(1'b0, fault_spi_pkg::ADDR_GLOBAL, 8'h00);
    `CHK(rsp[7:0], 8'h0A)
    warn <= 1'b0;
    wt(4);
    acc(1'b1, fault_spi_pkg::ADDR_GLOBAL, 8'h00);
    acc(1'b0, fault_spi_pkg::ADDR_GLOBAL, 8'h00);
    `CHK(rsp[7:0], 8'h08)
    shut <= 1'b1;
    wt(8);
    `CHK(hs_on, 8'h00)
    shut <= 1'b0;
    wt(8);
    `CHK(ls_on, 8'h00)
    acc(1'b0, fault_spi_pkg::ADDR_GLOBAL, 8'h00);
    `CHK(rsp[7:0], 8'h0C)
    acc(1'b1, fault_spi_pkg::ADDR_GLOBAL, 8'h00);
    `CHK(hs_on, 8'h0F)
    $display("test thermal done");
    // Supply faults recover by themselves but keep their flag
    for (int k = 0; k < 2; k++) begin
      ulow <= (k == 0);
      uhigh <= (k == 1);
      wt(8);
      `CHK(hs_on, 8'h00)
      ulow <= 1'b0;
      uhigh <= 1'b0;
      wt(8);
      `CHK(ls_on, 8'hF0)
      acc(1'b0, fault_spi_pkg::ADDR_GLOBAL, 8'h00);
      `CHK(rsp[7:0], (k == 0) ? 8'h28 : 8'h18)
      acc(1'b1, fault_spi_pkg::ADDR_GLOBAL, 8'h00);
    end
    // A frame of eight clocks is discarded and raises the protocol flag
    m.xfer(8, 16'h0000, 1'b0, rsp, global_error_flag);
    poll(1'b0, 1'b1);
    acc(1'b0, fault_spi_pkg::ADDR_GLOBAL, 8'h00);
    `CHK(rsp[7:0], 8'h88)
    acc(1'b1, fault_spi_pkg::ADDR_GLOBAL, 8'h00);
    poll(1'b0, 1'b0);
    $display("test supply done");
    // LED channel 0 flags after the short filter, channel 3 only after 1000
    acc(1'b1, fault_spi_pkg::ADDR_LED_CFG, 8'h01);
    `CHK(led_thr, 1'b1)
    hs_lc <= 8'h0B;
    hs_fw <= 8'h02;
    ls_lc <= 8'h10;
    ls_fw <= 8'h10;
    wt(300);
    acc(1'b0, fault_spi_pkg::ADDR_OL_HS, 8'h00);
    `CHK(rsp[7:0], 8'h01)
    wt(900);
    acc(1'b0, fault_spi_pkg::ADDR_OL_HS, 8'h00);
    `CHK(rsp, 16'h4809)
    `CHK(hs_on, 8'h0F)
    acc(1'b0, fault_spi_pkg::ADDR_OL_LS, 8'h00);
    `CHK(rsp[7:0], 8'h00)
    hs_lc <= 8'h00;
    acc(1'b1, fault_spi_pkg::ADDR_OL_HS, 8'h5A);
    acc(1'b0, fault_spi_pkg::ADDR_OL_HS, 8'h00);
    `CHK(rsp[7:0], 8'h00)
    // Long LED filter: quiet where the short one would have fired
    acc(1'b1, fault_spi_pkg::ADDR_LED_CFG, 8'h03);
    hs_lc <= 8'h01;
    wt(200);
    acc(1'b0, fault_spi_pkg::ADDR_OL_HS, 8'h00);
    `CHK(rsp[7:0], 8'h00)
    wt(100);
    acc(1'b0, fault_spi_pkg::ADDR_OL_HS, 8'h00);
    `CHK(rsp[7:0], 8'h01)
    `CHK(led_thr, 1'b1)
    hs_lc <= 8'h00;
    $display("test open load done");
    rst_n <= 1'b0;
    wt(2);
    `CHK(hs_on, 8'h00)
    rst_n <= 1'b1;
    wt(fault_spi_pkg::SETUP_CYC + 4);
    poll(1'b0, 1'b1);
    acc(1'b0, fault_spi_pkg::ADDR_GLOBAL, 8'h00);
    `CHK(rsp, 16'h0000)
    $display("test logic reset done");
    print_verdict();
  end
endmodule
`default_nettype wire
